/* include/trap_cr_regs.vh */
// Purpose: Shared constants for the trap evaluator and flag-bit logic.
// Assumes: Mask and flag bits use big-endian numbering (bit 0 is the MSB).
// Notes: Mask vector index = 4 - mask bit number.
`ifndef TRAP_CR_REGS_VH
`define TRAP_CR_REGS_VH

// Vector positions of the relation flags inside the five-bit mask
`define TRAP_LT_POS 4
`define TRAP_GT_POS 3
`define TRAP_EQ_POS 2
`define TRAP_ULT_POS 1
`define TRAP_UGT_POS 0

// Standard mask codes
`define TRAP_MASK_LT 5'h10
`define TRAP_MASK_LE 5'h14
`define TRAP_MASK_EQ 5'h04
`define TRAP_MASK_GE 5'h0C
`define TRAP_MASK_GT 5'h08
`define TRAP_MASK_NE 5'h18
`define TRAP_MASK_LLT 5'h02
`define TRAP_MASK_LLE 5'h06
`define TRAP_MASK_LGE 5'h05
`define TRAP_MASK_LGT 5'h01
`define TRAP_MASK_ALWAYS 5'h1F

// Offsets of the bits inside one four-bit flag field
`define CR_OFF_LT 2'h0
`define CR_OFF_GT 2'h1
`define CR_OFF_EQ 2'h2
`define CR_OFF_SO 2'h3

// Flag-bit operation codes
`define CR_OP_EQV 2'h0
`define CR_OP_XOR 2'h1
`define CR_OP_OR 2'h2
`define CR_OP_NOR 2'h3

// Reset values
`define CR_RESET 32'h00000000
`define TRAP_FLAGS_RESET 5'h00

`endif

/* hdl/trap_relation_compare.v */
// Purpose: Five relation flags from comparing operand A with a second value.
// Assumes: Purely combinational; the caller registers the result.
// Notes: Flags are placed at the mask vector positions.
`timescale 1ns/1ps
`include "trap_cr_regs.vh"

module trap_relation_compare #(
  parameter DATA_W = 32
) (
  input wire [DATA_W-1:0] operand_a, // First operand
  input wire [DATA_W-1:0] operand_b, // Second operand
  output reg [4:0] relation_flags    // Lt, gt, eq, ult, ugt
);

  always @* begin
    relation_flags = `TRAP_FLAGS_RESET;
    relation_flags[`TRAP_LT_POS] =
      ($signed(operand_a) < $signed(operand_b));
    relation_flags[`TRAP_GT_POS] =
      ($signed(operand_a) > $signed(operand_b));
    relation_flags[`TRAP_EQ_POS] = (operand_a == operand_b);
    relation_flags[`TRAP_ULT_POS] = (operand_a < operand_b);
    relation_flags[`TRAP_UGT_POS] = (operand_a > operand_b);
  end

endmodule

/* hdl/trap_condition_and_cr_bit_logic.v */
// Purpose: Trap-word condition evaluator and flag-register bit logic.
// Assumes: Requests are synchronous to sys_clk; one request per valid cycle.
// Notes: The flag register is indexed [0:31], bit 0 being the MSB.
`timescale 1ns/1ps
`include "trap_cr_regs.vh"

module trap_condition_and_cr_bit_logic #(
  parameter DATA_W = 32,
  parameter IMM_W = 16
) (
  input wire sys_clk,                        // Core clock, 40 MHz
  input wire rst_b,                          // Async reset, active low
  input wire trap_valid,                     // Trap instruction issued
  input wire trap_imm_form,                  // 1: immediate form
  input wire [4:0] trap_condition_mask,      // Five-bit trap mask
  input wire [DATA_W-1:0] operand_a_reg,     // Operand A value
  input wire [DATA_W-1:0] operand_b_reg,     // Operand B value
  input wire [IMM_W-1:0] signed_immediate,   // Immediate field
  input wire cr_op_valid,                    // Flag-bit operation issued
  input wire [1:0] cr_op_code,               // Eqv, xor, or, nor
  input wire [2:0] cr_dest_field,            // Destination field
  input wire [1:0] cr_dest_offset,           // Destination bit offset
  input wire [2:0] cr_src_a_field,           // First source field
  input wire [1:0] cr_src_a_offset,          // First source offset
  input wire [2:0] cr_src_b_field,           // Second source field
  input wire [1:0] cr_src_b_offset,          // Second source offset
  input wire cr_load_en,                     // Whole-register load
  input wire [31:0] cr_load_value,           // Value for whole load
  output reg trap_request,                   // One-cycle trap pulse
  output reg [4:0] trap_cause,               // Masked flags of last trap
  output reg [4:0] trap_relation,            // Raw flags of last compare
  output reg cr_op_done,                     // One-cycle op completion
  output reg [0:31] cond_flag_register       // Flag register contents
);

  // Bit address of a flag: four per field plus the offset
  function [4:0] cr_bit_index;
    input [2:0] field;
    input [1:0] offset;
    begin
      cr_bit_index = {field, offset};
    end
  endfunction

  wire [DATA_W-1:0] imm_extended;
  wire [DATA_W-1:0] second_operand;
  wire [4:0] relation_flags;
  wire [4:0] masked_flags;
  wire trap_hit;

  assign imm_extended =
    {{(DATA_W-IMM_W){signed_immediate[IMM_W-1]}}, signed_immediate};
  assign second_operand =
    trap_imm_form ? imm_extended : operand_b_reg;

  trap_relation_compare #(
    .DATA_W(DATA_W)
  ) u_compare (
    .operand_a(operand_a_reg),
    .operand_b(second_operand),
    .relation_flags(relation_flags)
  );

  // The mask is used as-is, so every standard code works unchanged
  assign masked_flags = relation_flags & trap_condition_mask;
  assign trap_hit = trap_valid & (|masked_flags);

  // Trap path: the block has no result port, so no register is written
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      trap_request <= 1'b0;
      trap_cause <= `TRAP_FLAGS_RESET;
      trap_relation <= `TRAP_FLAGS_RESET;
    end else begin
      trap_request <= trap_hit;
      if (trap_valid) begin
        trap_relation <= relation_flags;
      end
      if (trap_hit) begin
        trap_cause <= masked_flags;
      end
    end
  end

  wire [4:0] dest_idx;
  wire [4:0] src_a_idx;
  wire [4:0] src_b_idx;
  wire src_a_bit;
  wire src_b_bit;
  reg next_bit;

  assign dest_idx = cr_bit_index(cr_dest_field, cr_dest_offset);
  assign src_a_idx = cr_bit_index(cr_src_a_field, cr_src_a_offset);
  assign src_b_idx = cr_bit_index(cr_src_b_field, cr_src_b_offset);
  assign src_a_bit = cond_flag_register[src_a_idx];
  assign src_b_bit = cond_flag_register[src_b_idx];

  // Same source twice gives set, clear, copy or invert
  always @* begin
    case (cr_op_code)
      `CR_OP_EQV: next_bit = ~(src_a_bit ^ src_b_bit);
      `CR_OP_XOR: next_bit = src_a_bit ^ src_b_bit;
      `CR_OP_OR: next_bit = src_a_bit | src_b_bit;
      `CR_OP_NOR: next_bit = ~(src_a_bit | src_b_bit);
      default: next_bit = 1'b0;
    endcase
  end

  // Sources are read before the write lands, so in-place invert is safe.
  // A whole load in the same cycle lands on every bit but the destination bit, where the single-bit operation wins.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cond_flag_register <= `CR_RESET;
      cr_op_done <= 1'b0;
    end else begin
      cr_op_done <= cr_op_valid;
      if (cr_load_en) begin
        cond_flag_register <= cr_load_value;
      end
      if (cr_op_valid) begin
        cond_flag_register[dest_idx] <= next_bit;
      end
    end
  end

endmodule

/* dv/trap_cr_checker.sv */
// Purpose: Port-level assertions for the trap evaluator and flag-bit logic.
// Assumes: Single clock domain, async active-low reset.
// Notes: Relation flags are recomputed here so that mask gating is tied down.
`timescale 1ns/1ps
module trap_cr_checker #(parameter DATA_W = 32, parameter IMM_W = 16) (
  input wire sys_clk, rst_b, trap_valid, trap_imm_form, // Clock, controls
  input wire [4:0] trap_condition_mask, // Mask
  input wire [DATA_W-1:0] operand_a_reg, operand_b_reg, // Operands
  input wire [IMM_W-1:0] signed_immediate, // Immediate
  input wire cr_op_valid, cr_load_en, trap_request, cr_op_done, // Strobes
  input wire [4:0] trap_cause, trap_relation, // Trap results
  input wire [0:31] cond_flag_register // Flag register
);
  wire [DATA_W-1:0] sb = trap_imm_form ? {{(DATA_W-IMM_W){
    signed_immediate[IMM_W-1]}}, signed_immediate} : operand_b_reg;
  wire signed [DATA_W-1:0] sa = operand_a_reg;
  wire signed [DATA_W-1:0] ss = sb;
  wire [4:0] f = {sa < ss, sa > ss, operand_a_reg == sb,
    operand_a_reg < sb, operand_a_reg > sb};
  wire [4:0] hit = f & trap_condition_mask;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_trap; trap_valid && |hit; endsequence
  sequence s_quiet; !(trap_valid && |hit); endsequence
  chk_flag_compare: assert property (
    trap_valid |=> trap_relation == $past(f))
    else $error("relation flags wrong");
  chk_trap_fires: assert property (
    s_trap |=> trap_request && trap_cause == $past(hit))
    else $error("trap missing or wrong cause");
  chk_no_trap: assert property (
    s_quiet |=> !trap_request)
    else $error("trap without cause");
  chk_cause_hold: assert property (
    s_quiet |=> $stable(trap_cause))
    else $error("cause changed without trap");
  chk_always_mask: assert property (
    trap_valid && trap_condition_mask == 5'h1F |=> trap_request)
    else $error("unconditional mask did not trap");
  chk_signed_less: assert property (
    trap_valid && trap_condition_mask == 5'h10 && f[4] |=> trap_request)
    else $error("signed less not trapped");
  chk_unsigned_gt: assert property (
    trap_valid && trap_condition_mask == 5'h01 && !f[0] |=> !trap_request)
    else $error("unsigned greater misgated");
  chk_op_done: assert property (
    1 |=> cr_op_done == $past(cr_op_valid))
    else $error("op done pulse wrong");
  chk_flags_hold: assert property (
    !cr_op_valid && !cr_load_en |=> $stable(cond_flag_register))
    else $error("flag register changed while idle");
endmodule
bind trap_condition_and_cr_bit_logic trap_cr_checker
  #(.DATA_W(DATA_W), .IMM_W(IMM_W)) chk (.*);

/* dv/trap_condition_and_cr_bit_logic_tb.sv */
// Purpose: Self-checking bench for trap evaluation and flag-bit operations.
// Assumes: Inputs change on the rising edge by non-blocking assignment.
// Notes: Flag shadow is indexed [0:31] like the design's register.
`timescale 1ns/1ps
module trap_condition_and_cr_bit_logic_tb;
  reg sys_clk = 0, rst_b = 0, tv = 0, fi = 0, cv = 0, le = 0;
  reg [4:0] m = 0;
  reg [31:0] a = 0, b = 0, lv = 0;
  reg [15:0] im = 0;
  reg [1:0] op = 0, dof = 0, aof = 0, bof = 0;
  reg [2:0] df = 0, af = 0, bf = 0;
  reg [0:31] sh;
  wire tr, done;
  wire [4:0] tc, trl;
  wire [0:31] cr;
  integer n_mismatch = 0, compares = 0, i;
  reg [4:0] ms [0:11] = '{5'h10, 5'h14, 5'h04, 5'h0C, 5'h08, 5'h18,
    5'h02, 5'h06, 5'h05, 5'h01, 5'h1F, 5'h00};
  trap_condition_and_cr_bit_logic DUT (.sys_clk(sys_clk), .rst_b(rst_b),
    .trap_valid(tv), .trap_imm_form(fi), .trap_condition_mask(m),
    .operand_a_reg(a), .operand_b_reg(b), .signed_immediate(im),
    .cr_op_valid(cv), .cr_op_code(op), .cr_dest_field(df),
    .cr_dest_offset(dof), .cr_src_a_field(af), .cr_src_a_offset(aof),
    .cr_src_b_field(bf), .cr_src_b_offset(bof), .cr_load_en(le),
    .cr_load_value(lv), .trap_request(tr), .trap_cause(tc),
    .trap_relation(trl), .cr_op_done(done), .cond_flag_register(cr));
  initial forever #12.5 sys_clk = ~sys_clk;
  task ck(input [31:0] g, input [31:0] e);
    compares = compares + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Immediate form drives B with the complement so a wrong pick shows
  task trap(input f, input [4:0] mk, input [31:0] x, input [31:0] y);
    reg [31:0] yy;
    reg [4:0] r;
    begin
      yy = f ? {{16{y[15]}}, y[15:0]} : y;
      r = {$signed(x) < $signed(yy), $signed(x) > $signed(yy), x == yy,
        x < yy, x > yy};
      @(posedge sys_clk);
      tv <= 1; fi <= f; m <= mk; a <= x; b <= f ? ~y : y; im <= y[15:0];
      @(posedge sys_clk);
      tv <= 0;
      #1;
      ck(tr, |(r & mk));
      ck(trl, r);
      if (|(r & mk)) ck(tc, r & mk);
    end
  endtask
  task crop(input [1:0] c, input [4:0] d, input [4:0] s1, input [4:0] s2);
    begin
      case (c)
        0: sh[d] = ~(sh[s1] ^ sh[s2]);
        1: sh[d] = sh[s1] ^ sh[s2];
        2: sh[d] = sh[s1] | sh[s2];
        default: sh[d] = ~(sh[s1] | sh[s2]);
      endcase
      @(posedge sys_clk);
      cv <= 1; op <= c; df <= d[4:2]; dof <= d[1:0];
      af <= s1[4:2]; aof <= s1[1:0]; bf <= s2[4:2]; bof <= s2[1:0];
      @(posedge sys_clk);
      cv <= 0;
      #1;
      ck(done, 1);
      ck(cr, sh);
    end
  endtask
  task load(input [31:0] v);
    begin
      sh = v;
      @(posedge sys_clk);
      le <= 1; lv <= v;
      @(posedge sys_clk);
      le <= 0;
      #1;
      ck(cr, sh);
    end
  endtask
  task finish_test;
    begin
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    #20000;
    n_mismatch = n_mismatch + 1;
    finish_test;
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst_b <= 1;
    #1;
    ck(cr, 0);
    for (i = 0; i < 12; i = i + 1) begin
      trap(1, ms[i], 32'h00000005, 32'h0000FFFF);
      trap(0, ms[i], 32'h80000000, 32'h00000001);
      trap(0, ms[i], 32'h00000007, 32'h00000007);
    end
    load(32'hF0F00F0F);
    crop(0, 25, 25, 25);
    crop(1, 15, 15, 15);
    crop(2, 3, 9, 9);
    crop(3, 22, 18, 18);
    finish_test;
  end
endmodule
